// [hw/deeu_ctrl.sv]
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "deeu_map.svh"
// Behaviour
// - keys 55h then aah, in order, are needed before any erase or write
// - after the key pair, a start is taken in the next bus cycle only; other control writes are taken only while no cycle is running
// - key register is write-only and reads as zero
// - setting start bit inside the window launches the selected cycle
// - data eeprom spans addresses 7ffe00h to 7fffffh
// - array holds 256 words of 16 bits, each readable and writable
// - cycle runs in background; register bus never stalls for it
// - upper byte holds start, enable and error; lower byte the operation
// - control, key and address registers govern erase and write
// - start bit set-only by software, cleared by hardware at finish
// - operation needs enable bit 14; hardware clears it on completion
// - error flag set when reset kills a cycle, clear on success
// - erase codes select 8, 4, 1 words or 0100xx whole array
module deeu_ctrl #(
  parameter int unsigned PROG_CYC = `DEEU_PROG_CYC,
  parameter int unsigned WORDS    = 256
) (
  input  wire logic        core_clk_i,
  input  wire logic        rstn_i,
  input  wire logic        clk_en_i,
  input  wire logic        abort_rst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  output logic             irq_o
);

  // ----------------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------------
  wire logic acc    = psel_i && penable_i && clk_en_i;
  wire logic wr     = acc && pwrite_i;
  wire logic rd     = acc && !pwrite_i;
  wire logic hit_c  = paddr_i == `DEEU_CTRL_OFF;
  wire logic hit_k  = paddr_i == `DEEU_KEY_OFF;
  wire logic hit_a  = paddr_i == `DEEU_ADDR_OFF;
  wire logic hit_u  = paddr_i == `DEEU_ADDRU_OFF;
  wire logic hit_d  = paddr_i == `DEEU_DATA_OFF;
  wire logic hit_s  = paddr_i == `DEEU_STAT_OFF;
  wire logic hit_m  = paddr_i == `DEEU_MASK_OFF;
  wire logic mapped = hit_c | hit_k | hit_a | hit_u | hit_d | hit_s | hit_m;

  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i && penable_i && !mapped;

  // ----------------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------------
  deeu_pkg::deeu_key_t key_q, key_d;
  deeu_pkg::deeu_op_t  op_q;
  logic [15:0] ctrl_q;
  logic [15:0] addr_q;
  logic [7:0]  addru_q;
  logic [15:0] latch_q;
  logic [31:0] cnt_q;
  logic [3:0]  span_q;
  logic [7:0]  widx_q;
  logic [1:0]  stat_q;
  logic [1:0]  mask_q;
  logic [15:0] mem_q [WORDS];
  logic        busy;

  assign busy = ctrl_q[`DEEU_CTRL_START];

  // ----------------------------------------------------------------------------
  // unlock sequence
  // ----------------------------------------------------------------------------
  wire logic key_wr  = wr && hit_k;
  wire logic key_one = pwdata_i[7:0] == `DEEU_KEY1;
  wire logic key_two = pwdata_i[7:0] == `DEEU_KEY2;

  // window lasts exactly one bus cycle after the second key; any bus access
  // or an idle cycle closes it
  always_comb
  begin
    key_d = deeu_pkg::DEEU_KEY_IDLE;
    unique case (key_q)
      deeu_pkg::DEEU_KEY_IDLE:
      begin
        if (key_wr && key_one)
          key_d = deeu_pkg::DEEU_KEY_HALF;
      end
      deeu_pkg::DEEU_KEY_HALF:
      begin
        if (key_wr && key_two)
          key_d = deeu_pkg::DEEU_KEY_OPEN;
        else if (key_wr && key_one)
          key_d = deeu_pkg::DEEU_KEY_HALF;
        else if (!wr)
          key_d = deeu_pkg::DEEU_KEY_HALF;
      end
      deeu_pkg::DEEU_KEY_OPEN:
      begin
        // the setup phase of the next transfer must not spend the window,
        // or a back-to-back control write could never reach its access edge
        if (key_wr && key_one)
          key_d = deeu_pkg::DEEU_KEY_HALF;
        else if (psel_i && !penable_i)
          key_d = deeu_pkg::DEEU_KEY_OPEN;
      end
      default: key_d = deeu_pkg::DEEU_KEY_IDLE;
    endcase
  end

  // ----------------------------------------------------------------------------
  // operation decode
  // ----------------------------------------------------------------------------
  wire logic [5:0] opc    = pwdata_i[5:0];
  wire logic       era    = pwdata_i[`DEEU_CTRL_ERASE];
  wire logic       c_wr   = wr && hit_c;
  wire logic       in_win = key_q == deeu_pkg::DEEU_KEY_OPEN;
  wire logic       en_new = pwdata_i[`DEEU_CTRL_OPEN] | ctrl_q[`DEEU_CTRL_OPEN];
  wire logic       go     = c_wr && in_win && pwdata_i[`DEEU_CTRL_START]
                            && en_new && !busy;
  wire logic [3:0] span   = (opc == `DEEU_OP_ER8) ? 4'h8 :
                            (opc == `DEEU_OP_ER4) ? 4'h4 : 4'h1;
  wire logic       bulk   = era && opc[5:2] == `DEEU_OP_BULK_HI;
  wire logic       erv    = era && (bulk || opc == `DEEU_OP_ER8 ||
                            opc == `DEEU_OP_ER4 || opc == `DEEU_OP_ER1);
  wire logic       wrv    = !era && opc[5:2] == `DEEU_OP_WR_HI;
  // byte address of the target; bit 0 is the phantom byte lane
  wire logic [23:0] ea    = {addru_q, addr_q};
  wire logic        in_ee = ea >= `DEEU_EE_BASE && ea <= `DEEU_EE_TOP;
  wire logic [7:0]  base  = ea[8:1];
  wire logic        done  = busy && cnt_q == 32'h0000_0001;

  // ----------------------------------------------------------------------------
  // control register and cycle timer
  // ----------------------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      key_q   <= deeu_pkg::DEEU_KEY_IDLE;
      op_q    <= deeu_pkg::DEEU_OP_NONE;
      ctrl_q  <= `DEEU_CTRL_RST;
      addr_q  <= 16'h0000;
      addru_q <= 8'h00;
      latch_q <= 16'h0000;
      cnt_q   <= 32'h0000_0000;
      span_q  <= 4'h0;
      widx_q  <= 8'h00;
    end
    else if (clk_en_i)
    begin
      key_q <= key_d;
      if (abort_rst_i && busy)
      begin
        // a kill mid-cycle leaves the words unknown, so flag it
        ctrl_q[`DEEU_CTRL_START] <= 1'b0;
        ctrl_q[`DEEU_CTRL_OPEN]  <= 1'b0;
        ctrl_q[`DEEU_CTRL_ERR]   <= 1'b1;
        op_q  <= deeu_pkg::DEEU_OP_NONE;
        cnt_q <= 32'h0000_0000;
      end
      else if (done)
      begin
        ctrl_q[`DEEU_CTRL_START] <= 1'b0;
        ctrl_q[`DEEU_CTRL_OPEN]  <= 1'b0;
        ctrl_q[`DEEU_CTRL_ERR]   <= 1'b0;
        op_q  <= deeu_pkg::DEEU_OP_NONE;
        cnt_q <= 32'h0000_0000;
      end
      else if (busy)
        cnt_q <= cnt_q - 32'h0000_0001;
      else if (c_wr)
      begin
        // error flag is kept: a control write never clears it
        ctrl_q <= (pwdata_i[15:0] & `DEEU_CTRL_WMASK) | (ctrl_q & 16'h2000);
        if (go)
        begin
          ctrl_q[`DEEU_CTRL_START] <= 1'b1;
          cnt_q  <= PROG_CYC;
          span_q <= bulk ? 4'h0 : span;
          widx_q <= bulk ? 8'h00 : base;
          op_q   <= (erv && (bulk || in_ee)) ? deeu_pkg::DEEU_OP_ERASE :
                    (wrv && in_ee) ? deeu_pkg::DEEU_OP_WRITE :
                    deeu_pkg::DEEU_OP_NONE;
        end
      end
      // address and latch are frozen while a cycle uses them
      if (!busy && wr && hit_a)
        addr_q <= {pwdata_i[15:1], 1'b0};
      if (!busy && wr && hit_u)
        addru_q <= {1'b0, pwdata_i[6:0]};
      if (!busy && wr && hit_d)
        latch_q <= pwdata_i[15:0];
    end
  end

  // ----------------------------------------------------------------------------
  // array
  // ----------------------------------------------------------------------------
  wire logic pgm_only = ctrl_q[`DEEU_CTRL_PGMONLY];
  // without program-only, a write erases first; model keeps the final value
  for (genvar i = 0; i < WORDS; i++)
  begin : g_word
    wire logic [7:0] off  = 8'(i) - widx_q;
    wire logic       hitw = (i == int'(widx_q));
    wire logic       hite = (span_q == 4'h0) || ({4'h0, off} < {4'h0, span_q} &&
                            8'(i) >= widx_q);
    always_ff @(posedge core_clk_i)
    begin
      if (clk_en_i && done && !abort_rst_i)
      begin
        if (op_q == deeu_pkg::DEEU_OP_ERASE && hite)
          mem_q[i] <= 16'hffff;
        else if (op_q == deeu_pkg::DEEU_OP_WRITE && hitw)
          mem_q[i] <= pgm_only ? (mem_q[i] & latch_q) : latch_q;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // interrupt: bit0 cycle done, bit1 cycle aborted
  // ----------------------------------------------------------------------------
  wire logic [1:0] ev   = {abort_rst_i && busy, done && !abort_rst_i};
  wire logic       s_rd = rd && hit_s;

  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      stat_q <= 2'b00;
      mask_q <= 2'b00;
    end
    else if (clk_en_i)
    begin
      stat_q <= (s_rd ? 2'b00 : stat_q) | ev;
      if (wr && hit_m)
        mask_q <= pwdata_i[1:0];
    end
  end

  assign irq_o = |(stat_q & mask_q);

  // ----------------------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------------------
  wire logic [15:0] rword = mem_q[base];
  wire logic [31:0] rmux  =
    hit_c ? {16'h0000, ctrl_q} :
    hit_a ? {16'h0000, addr_q} :
    hit_u ? {24'h000000, addru_q} :
    hit_d ? {16'h0000, (in_ee ? rword : 16'h0000)} :
    hit_s ? {30'h0, stat_q} :
    hit_m ? {30'h0, mask_q} : 32'h0000_0000;

  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      prdata_o <= 32'h0000_0000;
    else if (clk_en_i && psel_i && !penable_i && !pwrite_i)
      prdata_o <= rmux;
  end

  // ----------------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------------
  a_start_needs_key: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    clk_en_i && !busy && $past(clk_en_i) ##1 busy |-> $past(in_win))
    else $error("cycle started outside unlock window");
  a_start_set_go: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    clk_en_i && go && !abort_rst_i |=> busy)
    else $error("start bit not set after valid start");
  a_no_en_no_go: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    clk_en_i && c_wr && !en_new && !busy |=> !busy)
    else $error("cycle started without enable");
  a_done_clears: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    clk_en_i && done && !abort_rst_i |=> !ctrl_q[15] && !ctrl_q[14] && !ctrl_q[13])
    else $error("completion did not clear start and enable");
  a_abort_flags: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    clk_en_i && abort_rst_i && busy |=> ctrl_q[13] && !busy)
    else $error("abort did not set error flag");
  a_key_read_zero: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    clk_en_i && psel_i && !penable_i && !pwrite_i && hit_k |=> prdata_o == 32'h0)
    else $error("key register read non-zero");
  a_window_closes: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    clk_en_i && in_win && !(psel_i && !penable_i) |=> !in_win)
    else $error("unlock window lasted beyond one cycle");
  a_no_stall: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    busy |-> pready_o)
    else $error("bus stalled during cycle");

  // ----------------------------------------------------------------------------
  // checks on sequencing, array and status
  // ----------------------------------------------------------------------------
  // a stray key or a plain write in the idle state must never open the window
  a_idle_no_window: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    clk_en_i && key_q == deeu_pkg::DEEU_KEY_IDLE |=> !in_win)
    else $error("window opened without first key");

  a_pair_opens: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    clk_en_i && key_q == deeu_pkg::DEEU_KEY_HALF && key_wr && key_two |=> in_win)
    else $error("key pair did not open window");

  a_busy_holds: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    clk_en_i && busy && !done && !abort_rst_i |=> busy)
    else $error("start bit dropped before cycle end");

  a_addr_frozen: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    clk_en_i && busy && wr && hit_a |=> $stable(addr_q))
    else $error("address changed during cycle");

  a_err_kept: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    clk_en_i && c_wr && !busy && ctrl_q[13] |=> ctrl_q[13])
    else $error("control write cleared error flag");

  a_abort_status: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    clk_en_i && abort_rst_i && busy |=> stat_q[1])
    else $error("abort not recorded in status");

  a_done_status: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    clk_en_i && done && !abort_rst_i |=> stat_q[0])
    else $error("completion not recorded in status");

  a_ctrl_unused: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    ctrl_q[11:7] == 5'h00)
    else $error("unused control bits set");

  // frozen clock enable must hold every register, the control word included
  a_enable_freeze: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    !clk_en_i |=> $stable(ctrl_q))
    else $error("control changed with clock enable low");

  a_write_lands: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    clk_en_i && done && !abort_rst_i && op_q == deeu_pkg::DEEU_OP_WRITE && !pgm_only
    |=> mem_q[widx_q] == latch_q)
    else $error("written word not in array");

  a_bulk_erases: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    clk_en_i && done && !abort_rst_i && op_q == deeu_pkg::DEEU_OP_ERASE && span_q == 4'h0
    |=> mem_q[0] == 16'hffff && mem_q[WORDS-1] == 16'hffff)
    else $error("bulk erase left words set");

endmodule : deeu_ctrl

// [hw/deeu_map.svh]
`ifndef DEEU_MAP_SVH
`define DEEU_MAP_SVH

// ----------------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------------
`define DEEU_CTRL_OFF      12'h000
`define DEEU_KEY_OFF       12'h004
`define DEEU_ADDR_OFF      12'h008
`define DEEU_ADDRU_OFF     12'h00c
`define DEEU_DATA_OFF      12'h010
`define DEEU_STAT_OFF      12'h014
`define DEEU_MASK_OFF      12'h018

// ----------------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------------
`define DEEU_CTRL_START    15
`define DEEU_CTRL_OPEN     14
`define DEEU_CTRL_ERR      13
`define DEEU_CTRL_PGMONLY  12
`define DEEU_CTRL_ERASE    6
`define DEEU_CTRL_RST      16'h0000
`define DEEU_CTRL_WMASK    16'h507f

// ----------------------------------------------------------------------------
// key values, window and operation codes
// ----------------------------------------------------------------------------
`define DEEU_KEY1          8'h55
`define DEEU_KEY2          8'haa
`define DEEU_OP_ER8        6'h1a
`define DEEU_OP_ER4        6'h19
`define DEEU_OP_ER1        6'h18
`define DEEU_OP_BULK_HI    4'h4
`define DEEU_OP_WR_HI      4'h1
`define DEEU_EE_BASE       24'h7ffe00
`define DEEU_EE_TOP        24'h7fffff

// ----------------------------------------------------------------------------
// cycle timing
// ----------------------------------------------------------------------------
`define DEEU_CLK_NS        50
`define DEEU_PROG_NS       4000000
`define DEEU_PROG_CYC      (`DEEU_PROG_NS / `DEEU_CLK_NS)

`endif

// [hw/deeu_pkg.sv]
package deeu_pkg;

  typedef enum logic [1:0] {
    DEEU_KEY_IDLE = 2'b00,
    DEEU_KEY_HALF = 2'b01,
    DEEU_KEY_OPEN = 2'b10
  } deeu_key_t;

  typedef enum logic [1:0] {
    DEEU_OP_NONE  = 2'b00,
    DEEU_OP_ERASE = 2'b01,
    DEEU_OP_WRITE = 2'b10
  } deeu_op_t;

endpackage : deeu_pkg

// [verification/tb_data_eeprom_unlock_control.sv]
`timescale 1ns/1ps
`include "deeu_map.svh"
module tb_data_eeprom_unlock_control;
  localparam int unsigned PC = 20;
  logic        clk;
  logic        rstn;
  logic        clk_en;
  logic        abort;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic [31:0] rd;
  logic        err;
  logic [15:0] mem_m [256];
  logic [15:0] d;
  logic [5:0]  op;
  int          mismatches = 0;
  int          comparisons = 0;
  int          idx;
  int          base;

  deeu_ctrl #(.PROG_CYC(PC)) uut (.core_clk_i(clk), .rstn_i(rstn), .clk_en_i(clk_en),
    .abort_rst_i(abort), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .irq_o(irq));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ---------------------------------------------------------------------------
  // bus and checking helpers
  // ---------------------------------------------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task wrap_up;
    if (mismatches == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : wrap_up

  // leaves the request up so the next call can follow with no idle cycle
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] dat);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= dat;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
  endtask : apb

  task idle;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : idle

  task wr(input logic [11:0] a, input logic [31:0] dat);
    apb(1'b1, a, dat);
    idle;
  endtask : wr

  task rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    idle;
    check(rd, exp);
  endtask : rdc

  // the start must follow the second key back to back, or the window closes
  task kick(input logic [15:0] c);
    apb(1'b1, `DEEU_KEY_OFF, 32'h55);
    apb(1'b1, `DEEU_KEY_OFF, 32'haa);
    apb(1'b1, `DEEU_CTRL_OFF, {16'h0, c});
    idle;
  endtask : kick

  task set_addr(input int i, input logic [7:0] au);
    wr(`DEEU_ADDRU_OFF, {24'h0, au});
    wr(`DEEU_ADDR_OFF, 32'hfe00 + 32'(i * 2));
  endtask : set_addr

  task peek(input int i);
    set_addr(i, 8'h7f);
    rdc(`DEEU_DATA_OFF, {16'h0, mem_m[i]});
  endtask : peek

  task do_op(input int i, input logic [15:0] dat, input logic [15:0] c,
             input logic [7:0] au);
    int n;
    set_addr(i, au);
    wr(`DEEU_DATA_OFF, {16'h0, dat});
    kick(c | 16'h8000);
    apb(1'b0, `DEEU_CTRL_OFF, 32'h0);
    idle;
    check({31'h0, rd[15]}, 32'h1);
    n = 0;
    do
    begin
      apb(1'b0, `DEEU_CTRL_OFF, 32'h0);
      idle;
      n++;
    end
    while (rd[15] !== 1'b0 && n < 30);
    check({29'h0, rd[15:13]}, 32'h0);
    check({25'h0, rd[6:0]}, {25'h0, c[6:0]});
    check({31'h0, irq}, 32'h1);
    rdc(`DEEU_STAT_OFF, 32'h1);
    check({31'h0, irq}, 32'h0);
  endtask : do_op

  function automatic int span(input logic [5:0] code);
    if (code[5:2] == `DEEU_OP_BULK_HI) return 256;
    if (code == `DEEU_OP_ER8) return 8;
    if (code == `DEEU_OP_ER4) return 4;
    return 1;
  endfunction : span

  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    wrap_up;
  end

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial
  begin
    rstn = 1'b0;
    clk_en = 1'b1;
    abort = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    void'($urandom(77));
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rdc(`DEEU_CTRL_OFF, 32'h0);
    rdc(`DEEU_STAT_OFF, 32'h0);
    rdc(`DEEU_MASK_OFF, 32'h0);
    check({31'h0, irq}, 32'h0);
    apb(1'b1, 12'h01c, 32'hffffffff);
    idle;
    check({31'h0, err}, 32'h1);
    wr(`DEEU_CTRL_OFF, 32'hffff);
    rdc(`DEEU_CTRL_OFF, 32'h507f);
    wr(`DEEU_KEY_OFF, 32'h55);
    rdc(`DEEU_KEY_OFF, 32'h0);
    wr(`DEEU_MASK_OFF, 32'h3);
    rdc(`DEEU_MASK_OFF, 32'h3);
    // a write while the clock enable is low must be lost
    clk_en <= 1'b0;
    wr(`DEEU_MASK_OFF, 32'h0);
    clk_en <= 1'b1;
    rdc(`DEEU_MASK_OFF, 32'h3);
    for (int k = 0; k < 6; k++)
    begin
      idx = (k == 0) ? 0 : (k == 1) ? 255 : int'($urandom % 256);
      d = 16'($urandom);
      do_op(idx, d, 16'h4004, 8'h7f);
      mem_m[idx] = d;
      peek(idx);
    end
    d = 16'($urandom);
    do_op(idx, d, 16'h5004, 8'h7f);
    mem_m[idx] = mem_m[idx] & d;
    peek(idx);
    // refused starts: wrong order, stray key, idle gap, enable clear
    for (int m = 0; m < 4; m++)
    begin
      set_addr(idx, 8'h7f);
      wr(`DEEU_DATA_OFF, $urandom);
      wr(`DEEU_CTRL_OFF, (m == 3) ? 32'h0004 : 32'h4004);
      apb(1'b1, `DEEU_KEY_OFF, (m == 0) ? 32'haa : 32'h55);
      if (m == 1) apb(1'b1, `DEEU_KEY_OFF, 32'h12);
      apb(1'b1, `DEEU_KEY_OFF, (m == 0) ? 32'h55 : 32'haa);
      if (m == 2) idle;
      apb(1'b1, `DEEU_CTRL_OFF, (m == 3) ? 32'h8004 : 32'hc004);
      idle;
      rdc(`DEEU_CTRL_OFF, (m == 3) ? 32'h0004 : 32'h4004);
      repeat (PC + 5) @(posedge clk);
      rdc(`DEEU_STAT_OFF, 32'h0);
      peek(idx);
    end
    // every erase size, one at the top end to see the span clipped
    for (int j = 0; j < 4; j++)
    begin
      op = (j == 0) ? `DEEU_OP_ER8 : (j == 1) ? `DEEU_OP_ER4 : (j == 2) ? `DEEU_OP_ER1
           : {`DEEU_OP_BULK_HI, 2'($urandom)};
      base = (j == 0) ? 250 : int'($urandom % 240);
      for (int i = base; i < base + 9 && i < 256; i++)
      begin
        mem_m[i] = 16'($urandom);
        do_op(i, mem_m[i], 16'h4004, 8'h7f);
      end
      do_op(base, 16'h0, {10'h101, op}, 8'h7f);
      for (int i = 0; i < 256; i++)
        if (span(op) == 256 || (i >= base && i < base + span(op))) mem_m[i] = 16'hffff;
      for (int i = base; i < base + 9 && i < 256; i++) peek(i);
    end
    // address outside the eeprom span changes nothing
    do_op(idx, 16'($urandom), 16'h4004, 8'h00);
    peek(idx);
    // a reset event in mid-cycle leaves the error flag, masked status bit
    wr(`DEEU_MASK_OFF, 32'h1);
    kick(16'hc004);
    repeat (5) @(posedge clk);
    abort <= 1'b1;
    @(posedge clk);
    abort <= 1'b0;
    @(posedge clk);
    apb(1'b0, `DEEU_CTRL_OFF, 32'h0);
    idle;
    check({30'h0, rd[15], rd[13]}, 32'h1);
    check({31'h0, irq}, 32'h0);
    rdc(`DEEU_STAT_OFF, 32'h2);
    do_op(idx, 16'($urandom), 16'h4004, 8'h7f);
    wrap_up;
  end
endmodule : tb_data_eeprom_unlock_control
